// ### digital_io_wait_port_bench.sv
// Self-checking bench for the digital I/O wait port
`timescale 1ns/10ps
`default_nettype none
module digital_io_wait_port_bench
    import dio_wait_pkg::*;
;
logic clk, reset, slot, ws, rlv, busy, done, met, tmo, refc, refl, v, tmo_s;
arb_mode_t arb [CH_N];
logic [CH_N-1:0] wr, pm, gnt;
logic [SEL_W-1:0] sel [CH_N];
logic [PORT_W-1:0] wd [CH_N];
logic [PORT_W-1:0] wo [CH_N];
logic [SEL_W-1:0] rls, wls;
logic [PSEL_W-1:0] rps;
logic [PORT_W-1:0] rpv;
logic [LINE_W-1:0] lin, lout, loe, ext, xo, xe;
logic [TRIG_W-1:0] ti, tr, tq, to, te;
logic [LB_W-1:0] li, lr, lq, lo, le, st, ll;
wait_kind_t wk;
logic signed [TMO_W-1:0] wt;
logic [31:0] rnd;
int miscompares, n_compared, c, l, p;
dio_wait_port DUT (.clk(clk), .reset(reset), .arb_mode(arb), .system_timing_slot(slot),
    .wr_req(wr), .wr_port_mode(pm), .wr_sel(sel), .wr_data(wd), .wr_oe(wo), .wr_grant(gnt),
    .rd_line_sel(rls), .rd_port_sel(rps), .rd_line_val(rlv), .rd_port_val(rpv),
    .digital_line_in(lin), .digital_line_out(lout), .digital_line_oe(loe),
    .trig_in(ti), .trig_out_req(tr), .trig_oe_req(tq), .trig_out(to), .trig_oe(te),
    .left_local_bus_line_in(li), .left_local_bus_line_out_req(lr), .left_local_bus_line_oe_req(lq),
    .left_local_bus_line_out(lo), .left_local_bus_line_oe(le), .star_trigger_in(st),
    .local_bus_left_in(ll), .chassis_reference_clock(refc), .chassis_reference_level(refl),
    .wait_start(ws), .wait_kind(wk), .wait_line_sel(wls), .wait_timeout(wt),
    .wait_busy(busy), .wait_done(done), .wait_met(met), .wait_timed_out(tmo));
ext_lines PM (.line_out(lout), .line_oe(loe), .ext_level(ext), .line_in(lin), .ref_clk(refc));
function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
endfunction
task chk(input string n, input logic [LINE_W-1:0] e, input logic [LINE_W-1:0] g);
    n_compared++;
    if (e !== g) begin
        miscompares++;
        $display("BAD %s exp %h got %h", n, e, g);
    end
endtask
task chk_n(input string n, input int lo_b, input int hi_b);
    n_compared++;
    if (c < lo_b || c > hi_b) begin
        miscompares++;
        $display("BAD %s exp %0d..%0d got %0d", n, lo_b, hi_b, c);
    end
endtask
// Line change on the d-th edge after the task starts, d-1 edges after the request is set up; one idle cycle after done
task run_wait(input wait_kind_t k, input int t, input int d);
    fork
        begin
            @(posedge clk);
            ws <= 1'b1;
            wk <= k;
            wt <= t;
            @(posedge clk);
            ws <= 1'b0;
            c = 0;
            @(negedge clk);
            while (done !== 1'b1 && c < 60) begin
                @(negedge clk);
                c++;
            end
            tmo_s = tmo;
        end
        if (d > 0) begin
            repeat (d) @(posedge clk);
            ext[l] <= v;
        end
    join
    @(posedge clk);
endtask
task wrt(input int ch, input logic m, input logic [PORT_W-1:0] d);
    @(posedge clk);
    wr[ch] <= 1'b1;
    pm[ch] <= m;
    sel[ch] <= m ? SEL_W'(p) : SEL_W'(l);
    wd[ch] <= d;
    wo[ch] <= 8'hff;
    rps <= PSEL_W'(p);
    rls <= SEL_W'(l);
    @(posedge clk);
    wr[ch] <= 1'b0;
    @(negedge clk);
    chk("line_out", xo, lout);
    chk("line_oe", xe, loe);
    chk("port_read", LINE_W'(xo[8*p+:8]), LINE_W'(rpv));
    chk("line_read", LINE_W'(xo[l]), LINE_W'(rlv));
endtask
task results;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
endtask
initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
end
// Whole run needs about 250 cycles
initial begin
    #200000;
    miscompares++;
    results;
end
initial begin
    {reset, slot, ws, wr, pm, rls, rps, ext, xo, xe, ti, tr, tq, li, lr, lq, wls, wt, v} = '1;
    {slot, ws, wr, pm, rls, rps, ext, xo, xe, ti, tr, tq, li, lr, lq, wls, wt, v} = '0;
    wk = WAIT_ANY;
    rnd = 32'hd4e908ce;
    foreach (arb[i]) begin
        arb[i] = ARB_NONE;
        sel[i] = '0;
        wd[i] = '0;
        wo[i] = '0;
    end
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    // Each kind against a line that starts on the wrong side; last one waits long
    for (int i = 0; i < 5; i++) begin
        rnd = lfsr(rnd);
        l = rnd % LINE_W;
        v = !(i == 1 || i == 4);
        ext[l] <= !v;
        wls <= SEL_W'(l);
        repeat (2) @(posedge clk);
        run_wait(wait_kind_t'(i), -1, 5 + 10 * i);
        chk_n("wait_cycles", 3 + 10 * i, 6 + 10 * i);
        chk("met", 1, LINE_W'(met));
    end
    $display("test edge waits done");
    for (int j = 0; j < 2; j++) begin
        v = !j[0];
        ext[l] <= v;
        run_wait(j ? WAIT_LOW : WAIT_HIGH, 10, 0);
        chk_n("level_now", 1, 1);
    end
    ext[l] <= 1'b0;
    for (int j = 0; j < 4; j++) begin
        rnd = lfsr(rnd);
        p = j == 1 ? 3 : j ? rnd % 20 + 1 : 0;
        run_wait(wait_kind_t'(j), p, 0);
        chk_n("timeout_cycles", p, p);
        chk("timed_out", 1, LINE_W'(tmo_s));
    end
    $display("test timeouts done");
    // Lines 0..47 written singly, ports 6..11 whole, never both; outside levels parked low
    ext <= '0;
    for (int i = 0; i < 8; i++) begin
        rnd = lfsr(rnd);
        p = 6 + rnd % 6;
        l = rnd[23:8] % 48;
        if (i[0]) begin
            xo[8*p+:8] = rnd[31:24];
            xe[8*p+:8] = 8'hff;
        end else begin
            xo[l] = rnd[24];
            xe[l] = 1'b1;
        end
        wrt(i % CH_N, i[0], rnd[31:24]);
    end
    $display("test writes done");
    // Two channels on one port; fixed lets channel 0 win, round robin picks one
    for (int m = 0; m < 2; m++) begin
        @(posedge clk);
        foreach (arb[i]) arb[i] <= m ? ARB_ROUND_ROBIN : ARB_FIXED;
        for (int k = 0; k < 2; k++) begin
            wr[k] <= 1'b1;
            pm[k] <= 1'b1;
            sel[k] <= SEL_W'(p);
            wd[k] <= (k == 1 && m == 0) ? ~xo[8*p+:8] : xo[8*p+:8];
            wo[k] <= 8'hff;
        end
        @(negedge clk);
        chk("grant", 1, m ? LINE_W'($countones(gnt)) : LINE_W'(gnt));
        @(posedge clk);
        wr <= '0;
        @(negedge clk);
        chk("arb_out", xo, lout);
    end
    $display("test arbitration done");
    for (int i = 0; i < 6; i++) begin
        @(posedge clk);
        rnd = lfsr(rnd);
        {ti, tr, tq} <= rnd[23:0];
        {li, lr, lq, slot} <= {rnd[31:0], rnd[7:0]};
        @(negedge clk);
        chk("trig_out", LINE_W'(tr), LINE_W'(to));
        chk("trig_oe", LINE_W'(tq), LINE_W'(te));
        chk("left_oe", slot ? '0 : LINE_W'(lq), LINE_W'(le));
        chk("left_in", LINE_W'(li), LINE_W'(slot ? st : ll));
        chk("ref_level", LINE_W'(refc), LINE_W'(refl));
    end
    $display("test trigger pins done");
    results;
end
endmodule // digital_io_wait_port_bench
`default_nettype wire

// ### dio_wait_pkg.sv
// Constants and types for the digital I/O wait port
package dio_wait_pkg;
    localparam int LINE_W = 96;
    localparam int PORT_W = 8;
    localparam int PORT_N = 12;
    localparam int SEL_W = 7;
    localparam int PSEL_W = 4;
    localparam int TRIG_W = 8;
    localparam int LB_W = 13;
    localparam int TMO_W = 32;
    localparam int CH_N = 4;
    // Connector 0 holds lines 0..15, connectors 1 and 2 hold 40 each
    localparam logic [SEL_W-1:0] CONN1_BASE = 7'h10;
    localparam logic [SEL_W-1:0] CONN2_BASE = 7'h38;
    localparam logic [TMO_W-1:0] TMO_ZERO = 32'h0000_0000;
    localparam logic [TMO_W-1:0] TMO_ONE = 32'h0000_0001;
    typedef enum logic [2:0] {
        WAIT_ANY = 3'h0,
        WAIT_FALL = 3'h1,
        WAIT_RISE = 3'h2,
        WAIT_HIGH = 3'h3,
        WAIT_LOW = 3'h4
    } wait_kind_t;
    typedef enum logic [1:0] {
        ARB_NONE = 2'h0,
        ARB_ROUND_ROBIN = 2'h1,
        ARB_FIXED = 2'h2
    } arb_mode_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_DONE = 2'b11
    } wait_state_t;
endpackage

// ### dio_wait_port.sv
// Digital I/O port with edge and level wait engine
`timescale 1ns/10ps
`default_nettype none
module dio_wait_port
    import dio_wait_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Configuration
    input wire arb_mode_t arb_mode [CH_N],
    input wire logic system_timing_slot,
    // Requesters per channel: output writes
    input wire logic [CH_N-1:0] wr_req,
    input wire logic [CH_N-1:0] wr_port_mode,
    input wire logic [SEL_W-1:0] wr_sel [CH_N],
    input wire logic [PORT_W-1:0] wr_data [CH_N],
    input wire logic [PORT_W-1:0] wr_oe [CH_N],
    output logic [CH_N-1:0] wr_grant,
    // Reads
    input wire logic [SEL_W-1:0] rd_line_sel,
    input wire logic [PSEL_W-1:0] rd_port_sel,
    output logic rd_line_val,
    output logic [PORT_W-1:0] rd_port_val,
    // Digital line pins
    input wire logic [LINE_W-1:0] digital_line_in,
    output logic [LINE_W-1:0] digital_line_out,
    output logic [LINE_W-1:0] digital_line_oe,
    // Chassis trigger and local bus pins
    input wire logic [TRIG_W-1:0] trig_in,
    input wire logic [TRIG_W-1:0] trig_out_req,
    input wire logic [TRIG_W-1:0] trig_oe_req,
    output logic [TRIG_W-1:0] trig_out,
    output logic [TRIG_W-1:0] trig_oe,
    input wire logic [LB_W-1:0] left_local_bus_line_in,
    input wire logic [LB_W-1:0] left_local_bus_line_out_req,
    input wire logic [LB_W-1:0] left_local_bus_line_oe_req,
    output logic [LB_W-1:0] left_local_bus_line_out,
    output logic [LB_W-1:0] left_local_bus_line_oe,
    output logic [LB_W-1:0] star_trigger_in,
    output logic [LB_W-1:0] local_bus_left_in,
    // Reference clock, read-only
    input wire logic chassis_reference_clock,
    output logic chassis_reference_level,
    // Wait engine
    input wire logic wait_start,
    input wire wait_kind_t wait_kind,
    input wire logic [SEL_W-1:0] wait_line_sel,
    input wire logic signed [TMO_W-1:0] wait_timeout,
    output logic wait_busy,
    output logic wait_done,
    output logic wait_met,
    output logic wait_timed_out
);

    // Flat line index into the 8n..8n+7 packing
    function automatic logic [SEL_W-1:0] port_base(input logic [PSEL_W-1:0] p);
        port_base = {p, 3'h0};
    endfunction

    // Port group a request touches, so line and port writers contend alike
    function automatic logic [PSEL_W-1:0] port_of(input logic [SEL_W-1:0] s, input logic m);
        port_of = m ? s[PSEL_W-1:0] : s[SEL_W-1:SEL_W-PSEL_W];
    endfunction

    logic [LINE_W-1:0] out_ff, oe_ff;
    logic [LINE_W-1:0] nxt_out, nxt_oe;
    logic [CH_N-1:0] rr_ptr_ff;
    logic [CH_N-1:0] grant_c;
    logic [LINE_W-1:0] line_prev_ff;
    wait_state_t state_ff;
    wait_kind_t kind_ff;
    logic [SEL_W-1:0] sel_ff;
    logic signed [TMO_W-1:0] cnt_ff;
    logic infinite_ff, met_ff, done_ff;
    logic cur_bit, prev_bit, hit;

    // Arbitration: channels writing overlapping ports contend in groups by mode
    always_comb begin
        grant_c = '0;
        for (int c = 0; c < CH_N; c++) begin
            if (wr_req[c]) begin
                grant_c[c] = 1'b1;
                for (int o = 0; o < CH_N; o++) begin
                    if (o != c && wr_req[o] &&
                        port_of(wr_sel[o], wr_port_mode[o]) == port_of(wr_sel[c], wr_port_mode[c])) begin
                        if (arb_mode[c] == ARB_FIXED && o < c)
                            grant_c[c] = 1'b0;
                        // Pointer owner wins; otherwise lower index, so one winner always
                        else if (arb_mode[c] == ARB_ROUND_ROBIN && (rr_ptr_ff[o] || (!rr_ptr_ff[c] && o < c)))
                            grant_c[c] = 1'b0;
                    end
                end
            end
        end
    end
    assign wr_grant = grant_c;

    always_ff @(posedge clk or posedge reset) begin
        if (reset)
            rr_ptr_ff <= 4'h1;
        else if (|wr_req)
            rr_ptr_ff <= {rr_ptr_ff[CH_N-2:0], rr_ptr_ff[CH_N-1]};
    end

    // Output data and enable update; port writes cover a whole byte
    always_comb begin
        nxt_out = out_ff;
        nxt_oe = oe_ff;
        for (int c = 0; c < CH_N; c++) begin
            if (grant_c[c]) begin
                if (wr_port_mode[c]) begin
                    for (int b = 0; b < PORT_W; b++) begin
                        nxt_out[port_base(wr_sel[c][PSEL_W-1:0]) + b] = wr_data[c][b];
                        nxt_oe[port_base(wr_sel[c][PSEL_W-1:0]) + b] = wr_oe[c][b];
                    end
                end else begin
                    nxt_out[wr_sel[c]] = wr_data[c][0];
                    nxt_oe[wr_sel[c]] = wr_oe[c][0];
                end
            end
        end
    end

    // Single cycle update keeps line access to one clock
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            out_ff <= '0;
            oe_ff <= '0;
        end else begin
            out_ff <= nxt_out;
            oe_ff <= nxt_oe;
        end
    end
    assign digital_line_out = out_ff;
    assign digital_line_oe = oe_ff;

    // Reads are combinational from the pins
    assign rd_line_val = digital_line_in[rd_line_sel];
    always_comb begin
        rd_port_val = '0;
        for (int b = 0; b < PORT_W; b++)
            rd_port_val[b] = digital_line_in[port_base(rd_port_sel) + b];
    end

    // Triggers and local bus; star drive is blocked in the timing slot
    assign trig_out = trig_out_req;
    assign trig_oe = trig_oe_req;
    assign left_local_bus_line_out = left_local_bus_line_out_req;
    assign left_local_bus_line_oe = system_timing_slot ? '0 : left_local_bus_line_oe_req;
    assign star_trigger_in = system_timing_slot ? left_local_bus_line_in : '0;
    assign local_bus_left_in = system_timing_slot ? '0 : left_local_bus_line_in;
    // Passed straight through, not registered; there is no drive path and clk is never replaced by it
    assign chassis_reference_level = chassis_reference_clock;

    // Wait engine
    always_ff @(posedge clk or posedge reset) begin
        if (reset)
            line_prev_ff <= '0;
        else
            line_prev_ff <= digital_line_in;
    end
    assign cur_bit = digital_line_in[sel_ff];
    assign prev_bit = line_prev_ff[sel_ff];
    always_comb begin
        case (kind_ff)
            WAIT_ANY: hit = cur_bit ^ prev_bit;
            WAIT_FALL: hit = prev_bit & ~cur_bit;
            WAIT_RISE: hit = ~prev_bit & cur_bit;
            WAIT_HIGH: hit = cur_bit;
            WAIT_LOW: hit = ~cur_bit;
            default: hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_ff <= ST_IDLE;
            kind_ff <= WAIT_ANY;
            sel_ff <= '0;
            cnt_ff <= '0;
            infinite_ff <= 1'b0;
            met_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            case (state_ff)
                ST_IDLE: begin
                    if (wait_start) begin
                        kind_ff <= wait_kind;
                        sel_ff <= wait_line_sel;
                        cnt_ff <= wait_timeout;
                        infinite_ff <= wait_timeout[TMO_W-1];
                        if (wait_timeout == TMO_ZERO) begin
                            met_ff <= 1'b0;
                            done_ff <= 1'b1;
                            state_ff <= ST_DONE;
                        end else begin
                            state_ff <= ST_WAIT;
                        end
                    end
                end
                ST_WAIT: begin
                    if (hit) begin
                        met_ff <= 1'b1;
                        done_ff <= 1'b1;
                        state_ff <= ST_DONE;
                    end else if (!infinite_ff) begin
                        cnt_ff <= cnt_ff - TMO_ONE;
                        if (cnt_ff == TMO_ONE) begin
                            met_ff <= 1'b0;
                            done_ff <= 1'b1;
                            state_ff <= ST_DONE;
                        end
                    end
                end
                ST_DONE: state_ff <= ST_IDLE;
                default: state_ff <= ST_IDLE;
            endcase
        end
    end
    assign wait_busy = (state_ff == ST_WAIT);
    assign wait_done = done_ff;
    assign wait_met = met_ff;
    assign wait_timed_out = done_ff & ~met_ff;

    // Checks
    zero_timeout_a: assert property (@(posedge clk) disable iff (reset)
        state_ff == ST_IDLE && wait_start && wait_timeout == TMO_ZERO |=> wait_done && !wait_met)
        else $error("zero timeout did not end at once");
    high_level_a: assert property (@(posedge clk) disable iff (reset)
        wait_busy && kind_ff == WAIT_HIGH && cur_bit |=> wait_done && wait_met)
        else $error("high wait missed high line");
    low_level_a: assert property (@(posedge clk) disable iff (reset)
        wait_busy && kind_ff == WAIT_LOW && !cur_bit |=> wait_done && wait_met)
        else $error("low wait missed low line");
    rise_edge_a: assert property (@(posedge clk) disable iff (reset)
        wait_busy && kind_ff == WAIT_RISE && !prev_bit && cur_bit |=> wait_met && wait_done)
        else $error("rising wait missed edge");
    fall_edge_a: assert property (@(posedge clk) disable iff (reset)
        wait_busy && kind_ff == WAIT_FALL && prev_bit && !cur_bit |=> wait_met && wait_done)
        else $error("falling wait missed edge");
    any_edge_a: assert property (@(posedge clk) disable iff (reset)
        wait_busy && kind_ff == WAIT_ANY && cur_bit != prev_bit |=> wait_done && wait_met)
        else $error("any-edge wait missed transition");
    endless_wait_a: assert property (@(posedge clk) disable iff (reset)
        wait_busy && infinite_ff && !hit |=> !wait_done)
        else $error("negative timeout expired");
    timeout_count_a: assert property (@(posedge clk) disable iff (reset)
        state_ff == ST_IDLE && wait_start && wait_timeout == 32'sd3 ##1 !hit [*3] |=> wait_timed_out)
        else $error("timeout count wrong");
    star_block_a: assert property (@(posedge clk) disable iff (reset)
        system_timing_slot |-> left_local_bus_line_oe == '0)
        else $error("star line driven in timing slot");
    line_write_a: assert property (@(posedge clk) disable iff (reset)
        grant_c[0] && !wr_port_mode[0] |=> digital_line_out[$past(wr_sel[0])] == $past(wr_data[0][0]))
        else $error("line write not applied");
    met_cov: cover property (@(posedge clk) wait_done && wait_met);
    tmo_cov: cover property (@(posedge clk) wait_done && !wait_met);
    port_cov: cover property (@(posedge clk) |(grant_c & wr_port_mode));
    arb_cov: cover property (@(posedge clk) &wr_req && wr_grant != wr_req);

endmodule // dio_wait_port
`default_nettype wire

// ### ext_lines.sv
// Far-side model: outside line levels and chassis reference clock
`timescale 1ns/10ps
`default_nettype none
module ext_lines
    import dio_wait_pkg::*;
(
    // Pins
    input wire logic [LINE_W-1:0] line_out,
    input wire logic [LINE_W-1:0] line_oe,
    input wire logic [LINE_W-1:0] ext_level,
    output logic [LINE_W-1:0] line_in,
    // Reference
    output logic ref_clk
);
    // Driven lines show the pin value, released ones the outside level
    assign line_in = (line_out & line_oe) | (ext_level & ~line_oe);
    // Chassis reference free-runs at 10 MHz
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
endmodule // ext_lines
`default_nettype wire
